// ### hw/dmc_top.sv
// Functional notes
// - Pulse system error on ECC errors when enabled
// - Disabled option never drives system error
// - Mode none: no checking, no reporting
// - Correct-only: fix reads, no write-back
// - Hardware ECC: fix, write back, report multibit
// - Repeat single-bit at one of the last four scrubbed locations is uncorrectable
// - Refresh interval selectable, default 15.6 us
// - Memory hole at 15-16 MB or 512-640 KB
// - CAS latency two or three clocks
// - RAS to CAS delay two or three
// - Precharge two or three clocks before activate
// - Idle power-down when enabled, default off
`timescale 1ns/1ps
`default_nettype none
module dmc_top (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_n_i,
   // Configuration
   input  wire logic [1:0]          integ_mode_i,
   input  wire logic [2:0]          refresh_sel_i,
   input  wire logic [1:0]          hole_sel_i,
   input  wire logic                cas_lat3_i,
   input  wire logic                ras_cas3_i,
   input  wire logic                precharge3_i,
   input  wire logic                pdown_en_i,
   input  wire logic                serr_en_i,
   input  wire logic                error_command_register_i,
   // Host request
   input  wire logic                req_valid_i,
   input  wire logic                req_write_i,
   input  wire logic [23:0]         req_addr_i,
   input  wire logic [31:0]         req_wdata_i,
   output logic                     req_ready_o,
   output logic                     rd_valid_o,
   output logic [31:0]              rd_data_o,
   output logic                     hole_o,
   // Memory side
   output logic                     mem_act_o,
   output logic                     mem_rd_o,
   output logic                     mem_wr_o,
   output logic                     mem_pre_o,
   output logic                     mem_ref_o,
   output logic                     mem_cke_o,
   output logic [23:0]              mem_addr_o,
   output logic [38:0]              mem_wdata_o,
   input  wire logic [38:0]         mem_rdata_i,
   // Status
   output logic                     serr_o,
   output logic                     single_err_o,
   output logic                     multi_err_o
);
   typedef enum logic [7:0] {
      ST_IDLE  = 8'b0000_0001,
      ST_ACT   = 8'b0000_0010,
      ST_RCD   = 8'b0000_0100,
      ST_CAS   = 8'b0000_1000,
      ST_LAT   = 8'b0001_0000,
      ST_SCRUB = 8'b0010_0000,
      ST_PRE   = 8'b0100_0000,
      ST_REF   = 8'b1000_0000
   } dmc_state_t;

   // Data bits sit at codeword positions that are not powers of two,
   // so a flipped check bit can never be mistaken for a data bit
   function automatic logic [5:0] dmc_pos(input int idx);
      int         n;
      logic [5:0] p;
      n = 0;
      p = 6'h00;
      for (int k = 1; k < dmc_pkg::CW_W; k++) begin
         if ((k & (k - 1)) != 0) begin
            if (n == idx) begin
               p = 6'(k);
            end
            n++;
         end
      end
      return p;
   endfunction

   // Hamming check bits plus an overall parity bit that makes the codeword even
   function automatic logic [6:0] dmc_ecc(input logic [31:0] d);
      logic [6:0] c;
      logic [5:0] pos;
      c = 7'h00;
      for (int i = 0; i < dmc_pkg::DATA_W; i++) begin
         pos = dmc_pos(i);
         for (int b = 0; b < 6; b++) begin
            if (pos[b]) begin
               c[b] = c[b] ^ d[i];
            end
         end
      end
      c[6] = ^{d, c[5:0]};
      return c;
   endfunction

   function automatic logic [1:0] dmc_lat(input logic three);
      return three ? dmc_pkg::LAT_THREE : dmc_pkg::LAT_TWO;
   endfunction

   dmc_scrub_if sif ();

   dmc_scrub_mem #(.DEPTH(dmc_pkg::SCRUB_TAGS)) u_mem (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .sif     (sif.mem)
   );

   dmc_state_t  st_q, st_d;
   logic [1:0]  cnt_q, cnt_d;
   logic        wr_q, wr_d;
   logic [23:0] addr_q, addr_d;
   logic [31:0] wdat_q, wdat_d;
   logic [31:0] rdat_q, rdat_d;
   logic        rval_q, rval_d;
   logic        serr_q, serr_d;
   logic        sgl_q, sgl_d;
   logic        mul_q, mul_d;
   logic [16:0] ref_cnt_q, ref_cnt_d;
   logic        ref_pend_q, ref_pend_d;
   logic        cke_q, cke_d;
   logic [3:0]  idle_q, idle_d;

   logic [6:0]  syn;
   logic [6:0]  recalc;
   logic        sbe;
   logic [31:0] fixed;
   logic        in_hole;
   logic [16:0] ref_limit;

   always_comb begin
      // Memory hole decode
      in_hole = 1'b0;
      if (hole_sel_i == dmc_pkg::DMC_HOLE_15M) begin
         in_hole = req_addr_i >= dmc_pkg::HOLE_HI_LO && req_addr_i <= dmc_pkg::HOLE_HI_HI;
      end else if (hole_sel_i == dmc_pkg::DMC_HOLE_512K) begin
         in_hole = req_addr_i >= dmc_pkg::HOLE_LO_LO && req_addr_i <= dmc_pkg::HOLE_LO_HI;
      end
   end

   always_comb begin
      recalc = dmc_ecc(mem_rdata_i[31:0]);
      // Top bit is parity over the whole received word, so a double error leaves it clear
      syn    = {^mem_rdata_i, recalc[5:0] ^ mem_rdata_i[37:32]};
      fixed  = mem_rdata_i[31:0];
      // Odd parity with a position past the codeword means three or more flips
      sbe    = syn[6] && syn[5:0] <= 6'(dmc_pkg::CW_W - 1);
      for (int i = 0; i < dmc_pkg::DATA_W; i++) begin
         if (sbe && syn[5:0] == dmc_pos(i)) begin
            fixed[i] = ~fixed[i];
         end
      end
   end

   assign ref_limit = 17'(dmc_pkg::REF_BASE_CYC << refresh_sel_i);

   always_comb begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      wr_d       = wr_q;
      addr_d     = addr_q;
      wdat_d     = wdat_q;
      rdat_d     = rdat_q;
      rval_d     = 1'b0;
      serr_d     = 1'b0;
      sgl_d      = 1'b0;
      mul_d      = 1'b0;
      ref_cnt_d  = ref_cnt_q + 17'h0_0001;
      ref_pend_d = ref_pend_q;
      cke_d      = cke_q;
      idle_d     = idle_q;
      if (ref_cnt_q >= ref_limit - 17'h0_0001) begin
         ref_cnt_d  = 17'h0_0000;
         ref_pend_d = 1'b1;
      end
      case (st_q)
         ST_IDLE: begin
            if (ref_pend_q) begin
               cke_d = 1'b1;
               st_d  = ST_REF;
            end else if (req_valid_i && !in_hole) begin
               cke_d  = 1'b1;
               wr_d   = req_write_i;
               addr_d = req_addr_i;
               wdat_d = req_wdata_i;
               st_d   = ST_ACT;
               idle_d = 4'h0;
            end else if (idle_q != 4'hF) begin
               idle_d = idle_q + 4'h1;
            end else begin
               cke_d = !pdown_en_i;
            end
         end
         ST_ACT: begin
            cnt_d = dmc_lat(ras_cas3_i) - 2'h1;
            st_d  = ST_RCD;
         end
         ST_RCD: begin
            if (cnt_q <= 2'h1) begin
               st_d = ST_CAS;
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         ST_CAS: begin
            if (wr_q) begin
               cnt_d = dmc_lat(precharge3_i);
               st_d  = ST_PRE;
            end else begin
               cnt_d = dmc_lat(cas_lat3_i);
               st_d  = ST_LAT;
            end
         end
         ST_LAT: begin
            if (cnt_q <= 2'h1) begin
               rdat_d = mem_rdata_i[31:0];
               rval_d = 1'b1;
               st_d   = ST_PRE;
               cnt_d  = dmc_lat(precharge3_i);
               if (integ_mode_i != dmc_pkg::DMC_INTEG_NONE && syn != 7'h00) begin
                  if (sbe) begin
                     rdat_d = fixed;
                     if (integ_mode_i == dmc_pkg::DMC_INTEG_ECC && sif.look_hit) begin
                        // Scrubbed already, so the fault is hard: the uncorrectable flag, not the single-bit one
                        mul_d = 1'b1;
                     end else begin
                        sgl_d = 1'b1;
                        if (integ_mode_i == dmc_pkg::DMC_INTEG_ECC) begin
                           wdat_d = fixed;
                           st_d   = ST_SCRUB;
                        end
                     end
                  end else begin
                     mul_d = 1'b1;
                  end
                  serr_d = serr_en_i && error_command_register_i;
               end
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         ST_SCRUB: begin
            // Write-back finishes before the next request is accepted
            cnt_d = dmc_lat(precharge3_i);
            st_d  = ST_PRE;
         end
         ST_PRE, ST_REF: begin
            if (cnt_q <= 2'h1) begin
               st_d = ST_IDLE;
               if (st_q == ST_REF) begin
                  ref_pend_d = 1'b0;
               end
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (st_q == ST_IDLE && ref_pend_q) begin
         cnt_d = dmc_lat(precharge3_i);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         st_q       <= ST_IDLE;
         cnt_q      <= 2'h0;
         wr_q       <= 1'b0;
         addr_q     <= 24'h00_0000;
         wdat_q     <= 32'h0000_0000;
         rdat_q     <= 32'h0000_0000;
         rval_q     <= 1'b0;
         serr_q     <= 1'b0;
         sgl_q      <= 1'b0;
         mul_q      <= 1'b0;
         ref_cnt_q  <= 17'h0_0000;
         ref_pend_q <= 1'b0;
         cke_q      <= 1'b1;
         idle_q     <= 4'h0;
      end else begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         wr_q       <= wr_d;
         addr_q     <= addr_d;
         wdat_q     <= wdat_d;
         rdat_q     <= rdat_d;
         rval_q     <= rval_d;
         serr_q     <= serr_d;
         sgl_q      <= sgl_d;
         mul_q      <= mul_d;
         ref_cnt_q  <= ref_cnt_d;
         ref_pend_q <= ref_pend_d;
         cke_q      <= cke_d;
         idle_q     <= idle_d;
      end
   end

   assign sif.rec_valid = st_q == ST_SCRUB;
   assign sif.rec_addr  = addr_q;
   // Lookup is registered inside, so present the address as soon as it is known
   assign sif.look_addr = addr_q;

   assign req_ready_o  = st_q == ST_IDLE && !ref_pend_q && !in_hole;
   assign hole_o       = req_valid_i && in_hole;
   assign rd_valid_o   = rval_q;
   assign rd_data_o    = rdat_q;
   assign mem_act_o    = st_q == ST_ACT;
   assign mem_rd_o     = st_q == ST_CAS && !wr_q;
   assign mem_wr_o     = (st_q == ST_CAS && wr_q) || st_q == ST_SCRUB;
   assign mem_pre_o    = st_q == ST_PRE && cnt_q == dmc_lat(precharge3_i);
   assign mem_ref_o    = st_q == ST_REF && cnt_q == dmc_lat(precharge3_i);
   assign mem_cke_o    = cke_q;
   assign mem_addr_o   = addr_q;
   assign mem_wdata_o  = {dmc_ecc(wdat_q), wdat_q};
   assign serr_o       = serr_q;
   assign single_err_o = sgl_q;
   assign multi_err_o  = mul_q;
endmodule
`default_nettype wire

// ### hw/dmc_pkg.sv
package dmc_pkg;

   localparam int CLK_MHZ          = 100;
   // Refresh base interval in tenths of a microsecond
   localparam int REF_BASE_TENTH_US = 156;
   localparam int REF_BASE_CYC     = REF_BASE_TENTH_US * CLK_MHZ / 10;

   localparam int ADDR_W           = 24;
   localparam int DATA_W           = 32;
   localparam int ECC_W            = 7;
   localparam int CW_W             = 39;

   // Memory hole bounds, byte addresses
   localparam logic [23:0] HOLE_HI_LO = 24'hF0_0000;
   localparam logic [23:0] HOLE_HI_HI = 24'hFF_FFFF;
   localparam logic [23:0] HOLE_LO_LO = 24'h08_0000;
   localparam logic [23:0] HOLE_LO_HI = 24'h09_FFFF;

   typedef enum logic [1:0] {
      DMC_INTEG_NONE = 2'h0,
      DMC_INTEG_CORR = 2'h1,
      DMC_INTEG_ECC  = 2'h2
   } dmc_integ_t;

   typedef enum logic [1:0] {
      DMC_HOLE_OFF = 2'h0,
      DMC_HOLE_15M = 2'h1,
      DMC_HOLE_512K = 2'h2
   } dmc_hole_t;

   typedef enum logic [2:0] {
      DMC_REF_15_6  = 3'h0,
      DMC_REF_31_2  = 3'h1,
      DMC_REF_62_4  = 3'h2,
      DMC_REF_124_8 = 3'h3,
      DMC_REF_249_6 = 3'h4
   } dmc_ref_t;

   localparam logic [1:0] LAT_TWO   = 2'h2;
   localparam logic [1:0] LAT_THREE = 2'h3;
   localparam int          SCRUB_TAGS = 4;

endpackage

// ### hw/dmc_scrub_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmc_scrub_if;
   logic        rec_valid;
   logic [23:0] rec_addr;
   logic [23:0] look_addr;
   logic        look_hit;
   modport ctrl (output rec_valid, output rec_addr, output look_addr, input look_hit);
   modport mem  (input rec_valid, input rec_addr, input look_addr, output look_hit);
endinterface
`default_nettype wire

// ### hw/dmc_scrub_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Remembers the last DEPTH locations scrubbed, so a repeat single-bit error there is seen as hard
module dmc_scrub_mem #(
   parameter int DEPTH = dmc_pkg::SCRUB_TAGS
) (
   // Clock and reset
   input  wire logic   clock_i,
   input  wire logic   rst_n_i,
   // Record and lookup
   dmc_scrub_if.mem    sif
);
   logic [23:0]          tag_q   [DEPTH];
   logic [23:0]          tag_d   [DEPTH];
   logic [DEPTH-1:0]     vld_q;
   logic [DEPTH-1:0]     vld_d;
   logic [$clog2(DEPTH)-1:0] ptr_q;
   logic [$clog2(DEPTH)-1:0] ptr_d;
   logic                 hit_q;
   logic                 hit_d;

   always_comb begin
      tag_d = tag_q;
      vld_d = vld_q;
      ptr_d = ptr_q;
      hit_d = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         if (vld_q[i] && tag_q[i] == sif.look_addr) begin
            hit_d = 1'b1;
         end
      end
      // Round-robin replacement: oldest entry is forgotten first
      if (sif.rec_valid) begin
         tag_d[ptr_q] = sif.rec_addr;
         vld_d[ptr_q] = 1'b1;
         ptr_d        = ptr_q + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         vld_q <= '0;
         ptr_q <= '0;
         hit_q <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            tag_q[i] <= 24'h00_0000;
         end
      end else begin
         vld_q <= vld_d;
         ptr_q <= ptr_d;
         hit_q <= hit_d;
         tag_q <= tag_d;
      end
   end

   assign sif.look_hit = hit_q;
endmodule
`default_nettype wire

// ### tb/dmc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_top_sva (
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   // Configuration
   input wire logic [1:0]  integ_mode_i,
   input wire logic [1:0]  hole_sel_i,
   input wire logic        cas_lat3_i,
   input wire logic        ras_cas3_i,
   input wire logic        precharge3_i,
   input wire logic        serr_en_i,
   input wire logic        error_command_register_i,
   // Request and memory side
   input wire logic        req_valid_i,
   input wire logic [23:0] req_addr_i,
   input wire logic        rd_valid_o,
   input wire logic        hole_o,
   input wire logic        mem_act_o,
   input wire logic        mem_rd_o,
   input wire logic        mem_wr_o,
   input wire logic        mem_pre_o,
   // Status
   input wire logic        serr_o,
   input wire logic        single_err_o,
   input wire logic        multi_err_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_serr_gated: assert property (serr_o |-> $past(serr_en_i && error_command_register_i))
      else $error("serr not enabled");
   a_none_quiet: assert property (integ_mode_i == 2'h0 |-> !(single_err_o || multi_err_o || serr_o))
      else $error("report in mode none");
   a_hole_map: assert property (req_valid_i |-> hole_o == (
      (hole_sel_i == 2'h1 && req_addr_i >= 24'hF0_0000) ||
      (hole_sel_i == 2'h2 && req_addr_i >= 24'h08_0000 && req_addr_i <= 24'h09_FFFF)))
      else $error("hole decode");
   a_rcd_two: assert property (mem_act_o && !ras_cas3_i |-> ##1 !(mem_rd_o || mem_wr_o) ##1 (mem_rd_o || mem_wr_o))
      else $error("act to cmd not 2");
   a_rcd_three: assert property (mem_act_o && ras_cas3_i |-> !(mem_rd_o || mem_wr_o) [*3] ##1 (mem_rd_o || mem_wr_o))
      else $error("act to cmd not 3");
   a_cas_two: assert property (mem_rd_o && !cas_lat3_i |-> ##1 !rd_valid_o [*2] ##1 rd_valid_o)
      else $error("latency not 2");
   a_cas_three: assert property (mem_rd_o && cas_lat3_i |-> ##1 !rd_valid_o [*3] ##1 rd_valid_o)
      else $error("latency not 3");
   a_pre_three: assert property (mem_pre_o && precharge3_i |-> ##1 !mem_act_o [*2])
      else $error("precharge short");
endmodule
bind dmc_top dmc_top_sva u_sva (.*);
`default_nettype wire

// ### tb/dmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stores whole codewords; read data shows only in the latency slot
module dmc_mem_model (
   // Clock and commands
   input  wire logic        clock_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic        lat3_i,
   input  wire logic [23:0] addr_i,
   input  wire logic [38:0] wdata_i,
   // Stuck-bit mask on reads
   input  wire logic [38:0] flip_i,
   // Read data
   output logic [38:0]      rdata_o
);
   logic [38:0] mem_q [256];
   logic [7:0]  addr_q;
   logic [2:0]  cnt_q;
   logic [38:0] last_q;
   initial begin
      foreach (mem_q[i]) mem_q[i] = '0;
      cnt_q = '0;
      last_q = '0;
   end
   always @(posedge clock_i) begin
      if (wr_i) mem_q[addr_i[9:2]] <= wdata_i;
      if (rd_i) begin
         addr_q <= addr_i[9:2];
         cnt_q <= 3'h1;
      end else if (cnt_q != 3'h0) cnt_q <= cnt_q + 3'h1;
      last_q <= rdata_o;
   end
   // Bus toggles outside the slot, so an early or late sample reads garbage
   always_comb begin
      if (cnt_q == {2'b01, lat3_i}) rdata_o = mem_q[addr_q] ^ flip_i;
      else rdata_o = ~last_q;
   end
endmodule
`default_nettype wire

// ### tb/test_dmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_dmc_top;
   logic        clock_i, rst_n_i, cas_lat3_i, ras_cas3_i, precharge3_i, pdown_en_i, serr_en_i;
   logic        error_command_register_i, req_valid_i, req_write_i, req_ready_o, rd_valid_o, hole_o;
   logic        mem_act_o, mem_rd_o, mem_wr_o, mem_pre_o, mem_ref_o, mem_cke_o;
   logic        serr_o, single_err_o, multi_err_o;
   logic [1:0]  integ_mode_i, hole_sel_i;
   logic [2:0]  refresh_sel_i, f_q;
   logic [23:0] req_addr_i, mem_addr_o, a;
   logic [31:0] req_wdata_i, rd_data_o, rd_q;
   logic [38:0] mem_wdata_o, mem_rdata_i, flip;
   int          error_cnt, check_count, wr_n, t, w0;
   int          rs [3] = '{0, 1, 4};
   logic [25:0] hp [4] = '{{2'h1, 24'hF0_0000}, {2'h1, 24'hFF_FFFF}, {2'h2, 24'h08_0000}, {2'h2, 24'h09_FFFF}};

   dmc_top u_dut (.*);
   dmc_mem_model u_mem (.clock_i(clock_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .lat3_i(cas_lat3_i),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .flip_i(flip), .rdata_o(mem_rdata_i));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   always @(negedge clock_i) if (mem_wr_o === 1'b1) wr_n++;

   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Request held until ready is seen high at an edge
   task automatic acc(input logic w, input logic [23:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_addr_i <= ad;
      req_wdata_i <= d;
      do @(negedge clock_i); while (req_ready_o !== 1'b1 && ++n < 2000);
      if (n >= 2000) error_cnt++;
      @(posedge clock_i);
      req_valid_i <= 1'b0;
      n = 0;
      if (!w) begin
         do @(negedge clock_i); while (rd_valid_o !== 1'b1 && ++n < 40);
         if (n >= 40) error_cnt++;
         rd_q = rd_data_o;
         f_q = {single_err_o, multi_err_o, serr_o};
      end
      repeat (8) @(posedge clock_i);
   endtask

   initial begin
      {rst_n_i, cas_lat3_i, ras_cas3_i, precharge3_i, pdown_en_i, serr_en_i, req_valid_i} = '0;
      {error_command_register_i, req_write_i, integ_mode_i, hole_sel_i, refresh_sel_i} = '0;
      {req_addr_i, req_wdata_i, flip} = '0;
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      {serr_en_i, error_command_register_i} <= 2'h3;
      @(negedge clock_i);
      chk(mem_cke_o, 1'b1);
      // Flags are judged only on words written first
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         // Timing settings stand in for what sizing software programs
         {cas_lat3_i, ras_cas3_i, precharge3_i} <= 3'(i);
         integ_mode_i <= 2'(i % 3);
         a = 24'h00_0100 + 24'(i * 4);
         acc(1'b1, a, 32'hA5C3_0000 + 32'(i));
         acc(1'b0, a, 32'h0000_0000);
         chk(rd_q, 32'hA5C3_0000 + 32'(i));
         chk(f_q, 3'h0);
      end
      for (int m = 0; m < 3; m++) begin
         @(posedge clock_i);
         integ_mode_i <= 2'(m);
         flip <= '0;
         a = 24'h00_0200 + 24'(m * 4);
         acc(1'b1, a, 32'h1234_5678);
         flip <= 39'h8;
         w0 = wr_n;
         acc(1'b0, a, 32'h0000_0000);
         chk(rd_q, (m == 0) ? 32'h1234_5670 : 32'h1234_5678);
         chk(f_q, (m == 0) ? 3'h0 : 3'h5);
         chk(39'(wr_n - w0), (m == 2) ? 39'h1 : 39'h0);
      end
      acc(1'b0, a, 32'h0000_0000);
      chk(f_q, 3'h3);
      flip <= '0;
      acc(1'b1, a, 32'hCAFE_0001);
      acc(1'b0, a, 32'h0000_0000);
      chk(rd_q, 32'hCAFE_0001);
      for (int k = 0; k < 3; k++) begin
         @(posedge clock_i);
         flip <= '0;
         {serr_en_i, error_command_register_i} <= (k == 0) ? 2'h3 : 2'(k);
         a = 24'h00_0300 + 24'(k * 4);
         acc(1'b1, a, 32'h0F0F_0F0F);
         flip <= (k == 0) ? 39'h3 : 39'h10;
         acc(1'b0, a, 32'h0000_0000);
         chk(f_q, (k == 0) ? 3'h3 : 3'h4);
      end
      flip <= '0;
      {serr_en_i, error_command_register_i} <= 2'h3;
      // Hole requests are refused for good, so the probe withdraws them
      for (int j = 0; j < 4; j++) begin
         @(posedge clock_i);
         {hole_sel_i, req_addr_i} <= hp[j];
         req_valid_i <= 1'b1;
         repeat (3) @(negedge clock_i);
         chk(hole_o, 1'b1);
         chk(req_ready_o, 1'b0);
         @(posedge clock_i);
         req_valid_i <= 1'b0;
      end
      acc(1'b1, 24'h0A_0000, 32'h7777_1111);
      acc(1'b0, 24'h0A_0000, 32'h0000_0000);
      chk(rd_q, 32'h7777_1111);
      hole_sel_i <= 2'h0;
      pdown_en_i <= 1'b1;
      repeat (30) @(posedge clock_i);
      @(negedge clock_i);
      chk(mem_cke_o, 1'b0);
      acc(1'b1, 24'h00_0400, 32'h5555_AAAA);
      acc(1'b0, 24'h00_0400, 32'h0000_0000);
      chk(rd_q, 32'h5555_AAAA);
      pdown_en_i <= 1'b0;
      for (int r = 0; r < 3; r++) begin
         @(posedge clock_i);
         refresh_sel_i <= 3'(rs[r]);
         t = 0;
         do @(negedge clock_i); while (mem_ref_o !== 1'b1 && ++t < 60000);
         t = 0;
         do begin
            @(negedge clock_i);
            t++;
         end while (mem_ref_o !== 1'b1 && t < 60000);
         chk(39'(t), 39'(1560 << rs[r]));
      end
      complete_run;
   end

   initial begin
      #1_000_000;
      error_cnt++;
      complete_run;
   end
endmodule
`default_nettype wire
